// file: logic/dsc_dual_crc_codec.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module dsc_dual_crc_codec #(
    parameter int unsigned CNT_BITS = dsc_pkg::CNT_W
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire dsc_pkg::dsc_bus_req_t bus_req,
    output var  logic [31:0]           bus_rdata,
    input  wire logic                  crc_preset,
    input  wire logic                  crc_gate_term,
    input  wire logic                  tx_data_enable,
    input  wire logic                  tx_serial_in,
    output var  logic                  tx_encoded_out,
    input  wire logic                  rx_encoded_in,
    input  wire logic                  rx_pass_gate_n,
    output var  logic                  rx_passthrough_out,
    output var  logic                  check_fail_flag,
    output var  logic                  irq
);
    import dsc_pkg::*;

    if (CNT_BITS < 1 || CNT_BITS > 16) begin : g_bad_cnt
        $error("counter width must be 1 to 16");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                soft_preset;
        logic                tx_out;
        logic                rx_out;
        logic                fail;
        logic [31:0]         rdata;
        logic [CNT_BITS-1:0] tx_bits;
        logic [CNT_BITS-1:0] rx_bits;
        logic [CNT_BITS-1:0] good_frames;
        logic [CNT_BITS-1:0] bad_frames;
        logic                preset_d;
        logic                tx_check_d;
    } dsc_core_t;

    dsc_core_t r;
    dsc_core_t next_r;

    // Check-phase detector starts high: idle lines after reset are no new phase
    localparam dsc_core_t CORE_RST = '{tx_check_d: 1'b1, default: '0};

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Saturating increment for the statistics counters
    function automatic logic [CNT_BITS-1:0] sat_inc(input logic [CNT_BITS-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    // Zero-extends a counter into a 16-bit register field
    function automatic logic [15:0] widen(input logic [CNT_BITS-1:0] v);
        logic [15:0] w;
        w = '0;
        w[CNT_BITS-1:0] = v;
        return w;
    endfunction

    // ------------------------------------------------------------
    // Preset and shift registers
    // ------------------------------------------------------------
    dsc_tx_in_t        tx_in;
    logic              preset_eff;
    logic [CRC_W-1:0]  tx_crc;
    logic [CRC_W-1:0]  rx_crc;

    always_comb begin
        preset_eff      = crc_preset | r.soft_preset;
        tx_in.preset    = preset_eff;
        tx_in.gate      = crc_gate_term;
        tx_in.enable    = tx_data_enable;
        tx_in.serial_in = tx_serial_in;
    end

    dsc_lfsr #(
        .WIDTH (CRC_W),
        .TAPS  (CRC_TAPS)
    ) u_tx_lfsr (
        .clock    (clock),
        .rst      (rst),
        .preset   (tx_in.preset),
        .gate     (tx_in.gate),
        .din      (tx_in.serial_in),
        .state    (tx_crc),
        .feedback ()
    );

    // Receive side has no gating: feedback runs whenever not presetting
    dsc_lfsr #(
        .WIDTH (CRC_W),
        .TAPS  (CRC_TAPS)
    ) u_rx_lfsr (
        .clock    (clock),
        .rst      (rst),
        .preset   (preset_eff),
        .gate     (1'b1),
        .din      (rx_encoded_in),
        .state    (rx_crc),
        .feedback ()
    );

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    logic            wr_ctrl;
    logic            wr_clear;
    logic            wr_enable;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_enable;
    logic [EV_W-1:0] ev_set;
    logic [31:0]     rd_value;

    always_comb begin
        wr_ctrl   = bus_req.wr && (bus_req.addr == OFS_CTRL);
        wr_clear  = bus_req.wr && (bus_req.addr == OFS_CLEAR);
        wr_enable = bus_req.wr && (bus_req.addr == OFS_ENABLE);
    end

    always_comb begin
        rd_value = RD_NONE;
        unique case (bus_req.addr)
            OFS_CTRL: begin
                rd_value[CTRL_PRESET_BIT] = r.soft_preset;
            end
            OFS_STATUS: begin
                rd_value[EV_W-1:0] = ev_status;
            end
            OFS_ENABLE: begin
                rd_value[EV_W-1:0] = ev_enable;
            end
            OFS_TX_REM: begin
                rd_value = tx_crc;
            end
            OFS_RX_REM: begin
                rd_value = rx_crc;
            end
            OFS_BITS: begin
                rd_value = {widen(r.rx_bits), widen(r.tx_bits)};
            end
            OFS_FRAMES: begin
                rd_value = {widen(r.bad_frames), widen(r.good_frames)};
            end
            default: begin
                rd_value = RD_NONE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    logic tx_check_now;
    logic preset_rise;
    logic next_fail;

    always_comb begin
        next_fail    = (rx_crc != GOOD_RESIDUE);
        tx_check_now = ~crc_gate_term & ~tx_data_enable & ~preset_eff;
        preset_rise  = preset_eff & ~r.preset_d;
        ev_set                = '0;
        ev_set[EV_PRESET]     = preset_rise;
        ev_set[EV_GOOD]       = r.fail & ~next_fail & ~preset_eff;
        ev_set[EV_BAD]        = preset_rise & r.fail & (r.rx_bits != '0);
        ev_set[EV_TX_CHECK]   = tx_check_now & ~r.tx_check_d;
    end

    dsc_events #(
        .N (EV_W)
    ) u_events (
        .clock     (clock),
        .rst       (rst),
        .set       (ev_set),
        .clear_wr  (wr_clear),
        .enable_wr (wr_enable),
        .wdata     (bus_req.wdata[EV_W-1:0]),
        .status    (ev_status),
        .enable    (ev_enable),
        .irq       (irq)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;

        // Registered data/check-bit select
        if (tx_in.gate | tx_in.enable) begin
            next_r.tx_out = tx_in.serial_in;
        end else begin
            next_r.tx_out = tx_crc[CRC_W-1];
        end

        // Pass-through holds while the gate is high
        if (!rx_pass_gate_n) begin
            next_r.rx_out = rx_encoded_in;
        end

        next_r.fail = next_fail;

        // Read data stand one cycle, zero otherwise
        next_r.rdata = bus_req.rd ? rd_value : RD_NONE;

        if (wr_ctrl) begin
            next_r.soft_preset = bus_req.wdata[CTRL_PRESET_BIT];
        end

        // Bits shifted since the last preset: tx only while crc_gate_term is high, rx every cycle
        if (preset_eff) begin
            next_r.tx_bits = '0;
            next_r.rx_bits = '0;
        end else begin
            if (crc_gate_term) begin
                next_r.tx_bits = sat_inc(r.tx_bits);
            end
            next_r.rx_bits = sat_inc(r.rx_bits);
        end

        // Frame tallies, judged at the next preset
        if (wr_ctrl && bus_req.wdata[CTRL_CLR_BIT]) begin
            next_r.good_frames = '0;
            next_r.bad_frames  = '0;
        end else if (preset_rise && (r.rx_bits != '0)) begin
            if (r.fail) begin
                next_r.bad_frames = sat_inc(r.bad_frames);
            end else begin
                next_r.good_frames = sat_inc(r.good_frames);
            end
        end

        next_r.preset_d   = preset_eff;
        next_r.tx_check_d = tx_check_now;
    end

    // ------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r <= CORE_RST;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        tx_encoded_out     = r.tx_out;
        rx_passthrough_out = r.rx_out;
        check_fail_flag    = r.fail;
        bus_rdata          = r.rdata;
    end

endmodule // dsc_dual_crc_codec
`default_nettype wire

// file: logic/dsc_pkg.sv
`default_nettype none
package dsc_pkg;

    // ------------------------------------------------------------
    // Polynomial
    // ------------------------------------------------------------
    localparam int unsigned CRC_W        = 32;
    localparam logic [31:0] CRC_TAPS     = 32'h04c1_1db6;
    localparam logic [31:0] CRC_PRESET   = 32'hffff_ffff;
    localparam logic [31:0] GOOD_RESIDUE = 32'h4704_dd7b;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 16;
    localparam int unsigned EV_W   = 4;

    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_CLEAR   = 8'h08;
    localparam logic [7:0] OFS_ENABLE  = 8'h0c;
    localparam logic [7:0] OFS_TX_REM  = 8'h10;
    localparam logic [7:0] OFS_RX_REM  = 8'h14;
    localparam logic [7:0] OFS_BITS    = 8'h18;
    localparam logic [7:0] OFS_FRAMES  = 8'h1c;

    localparam int unsigned CTRL_PRESET_BIT = 0;
    localparam int unsigned CTRL_CLR_BIT    = 1;

    localparam int unsigned EV_PRESET   = 0;
    localparam int unsigned EV_GOOD     = 1;
    localparam int unsigned EV_BAD      = 2;
    localparam int unsigned EV_TX_CHECK = 3;

    localparam logic [31:0] RD_NONE = 32'h0000_0000;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dsc_bus_req_t;

    typedef struct packed {
        logic preset;
        logic gate;
        logic enable;
        logic serial_in;
    } dsc_tx_in_t;

endpackage
`default_nettype wire

// file: logic/dsc_lfsr.sv
`timescale 1ns/1ns
`default_nettype none
module dsc_lfsr #(
    parameter int unsigned       WIDTH = dsc_pkg::CRC_W,
    parameter logic [WIDTH-1:0]  TAPS  = dsc_pkg::CRC_TAPS[WIDTH-1:0]
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             preset,
    input  wire logic             gate,
    input  wire logic             din,
    output var  logic [WIDTH-1:0] state,
    output var  logic             feedback
);
    import dsc_pkg::*;

    if (WIDTH < 2) begin : g_bad_width
        $error("dsc_lfsr needs at least two stages");
    end

    typedef struct packed {
        logic [WIDTH-1:0] q;
    } dsc_lfsr_state_t;

    dsc_lfsr_state_t r;
    dsc_lfsr_state_t next_r;

    always_comb begin
        feedback = gate & ~preset & (r.q[WIDTH-1] ^ din);
        next_r   = r;
        if (preset) begin
            next_r.q = {WIDTH{1'b1}};
        end else begin
            next_r.q = {r.q[WIDTH-2:0], feedback} ^ (TAPS & {WIDTH{feedback}});
        end
        state = r.q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

endmodule // dsc_lfsr
`default_nettype wire

// file: logic/dsc_events.sv
`timescale 1ns/1ns
`default_nettype none
module dsc_events #(
    parameter int unsigned N = dsc_pkg::EV_W
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [N-1:0] set,
    input  wire logic         clear_wr,
    input  wire logic         enable_wr,
    input  wire logic [N-1:0] wdata,
    output var  logic [N-1:0] status,
    output var  logic [N-1:0] enable,
    output var  logic         irq
);
    import dsc_pkg::*;

    if (N < 1 || N > DATA_W) begin : g_bad_n
        $error("dsc_events width out of range");
    end

    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] enable;
        logic         irq;
    } dsc_ev_state_t;

    dsc_ev_state_t r;
    dsc_ev_state_t next_r;

    always_comb begin
        next_r = r;
        // Set beats a clear in the same cycle
        next_r.status = (r.status & ~(clear_wr ? wdata : '0)) | set;
        if (enable_wr) begin
            next_r.enable = wdata;
        end
        next_r.irq = |(next_r.status & next_r.enable);
        status = r.status;
        enable = r.enable;
        irq    = r.irq;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule // dsc_events
`default_nettype wire

// file: testbench/dsc_codec_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dsc_codec_assertions (
    input wire logic clock,
    input wire logic rst,
    input wire dsc_pkg::dsc_bus_req_t bus_req,
    input wire logic crc_preset,
    input wire logic crc_gate_term,
    input wire logic tx_data_enable,
    input wire logic tx_serial_in,
    input wire logic tx_encoded_out,
    input wire logic rx_encoded_in,
    input wire logic rx_pass_gate_n,
    input wire logic rx_passthrough_out,
    input wire logic check_fail_flag
);
    import dsc_pkg::*;
    logic [5:0] drain_cnt;
    logic       soft_pre;

    // Shadow of the software preset level
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            soft_pre <= 1'b0;
        else if (bus_req.wr && bus_req.addr == OFS_CTRL)
            soft_pre <= bus_req.wdata[CTRL_PRESET_BIT];
    end

    // Cycles of plain shifting with zero feedback
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            drain_cnt <= 6'h0;
        else if (crc_preset || soft_pre || crc_gate_term || tx_data_enable)
            drain_cnt <= 6'h0;
        else if (drain_cnt != 6'h3f)
            drain_cnt <= drain_cnt + 6'h1;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    tx_fwd_a: assert property (
        (crc_gate_term || tx_data_enable) |=> tx_encoded_out == $past(tx_serial_in))
        else $error("tx output not data");
    tx_preset_a: assert property (
        crc_preset ##1 (!crc_gate_term && !tx_data_enable) |=> tx_encoded_out)
        else $error("tx preset not ones");
    tx_shift_a: assert property (
        crc_preset ##1 (!crc_gate_term && !tx_data_enable && !crc_preset) [*3]
        |=> tx_encoded_out)
        else $error("tx shift lost ones");
    tx_drain_a: assert property (drain_cnt >= 6'h22 |-> !tx_encoded_out)
        else $error("tx not drained");
    rx_pass_a: assert property (
        !rx_pass_gate_n |=> rx_passthrough_out == $past(rx_encoded_in))
        else $error("rx pass wrong");
    rx_hold_a: assert property (rx_pass_gate_n |=> $stable(rx_passthrough_out))
        else $error("rx hold broken");
    preset_fail_a: assert property (crc_preset |-> ##2 check_fail_flag)
        else $error("fail flag low after preset");
    fail_fall_a: assert property (
        $fell(check_fail_flag) |-> !$past(crc_preset, 2))
        else $error("fail flag fell in preset");
endmodule // dsc_codec_assertions

bind dsc_dual_crc_codec dsc_codec_assertions u_dsc_codec_assertions (
    .clock(clock), .rst(rst), .bus_req(bus_req),
    .crc_preset(crc_preset), .crc_gate_term(crc_gate_term),
    .tx_data_enable(tx_data_enable), .tx_serial_in(tx_serial_in),
    .tx_encoded_out(tx_encoded_out), .rx_encoded_in(rx_encoded_in),
    .rx_pass_gate_n(rx_pass_gate_n), .rx_passthrough_out(rx_passthrough_out),
    .check_fail_flag(check_fail_flag)
);
`default_nettype wire

// file: testbench/dsc_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module dsc_link_model (
    input  wire logic clock,
    output var  logic crc_preset,
    output var  logic crc_gate_term,
    output var  logic tx_data_enable,
    output var  logic tx_serial_in,
    output var  logic rx_encoded_in,
    output var  logic rx_pass_gate_n
);
    import dsc_pkg::*;
    logic        busy = 1'b0;
    logic [31:0] rq;
    logic [31:0] f;

    function automatic logic [31:0] step(input logic [31:0] q, input logic fb);
        return {q[30:0], fb} ^ ({32{fb}} & CRC_TAPS);
    endfunction

    initial begin
        {crc_preset, crc_gate_term, tx_data_enable} = 3'h0;
        {tx_serial_in, rx_encoded_in, rx_pass_gate_n} = 3'h2;
    end

    // Idle lines toggle, never stale
    always @(posedge clock) begin
        if (!busy) begin
            tx_serial_in <= ~tx_serial_in;
            rx_encoded_in <= ~rx_encoded_in;
        end
    end

    task automatic frame(input logic [31:0] word, input int nbits, input logic [31:0] target);
        logic acc;
        @(posedge clock);
        busy = 1'b1;
        crc_preset <= 1'b1;
        rq = CRC_PRESET;
        for (int i = 0; i < nbits; i++) begin
            @(posedge clock);
            crc_preset <= 1'b0;
            crc_gate_term <= 1'b1;
            tx_serial_in <= word[i];
            rx_encoded_in <= word[i];
            rq = step(rq, rq[31] ^ word[i]);
        end
        // Feedback bits that steer the rx register onto target
        for (int i = 0; i < 32; i++) begin
            acc = target[i];
            for (int j = 1; j <= i; j++)
                acc ^= f[31-i+j] & CRC_TAPS[j];
            f[31-i] = acc;
        end
        for (int k = 0; k < 32; k++) begin
            @(posedge clock);
            crc_preset <= 1'b0;
            crc_gate_term <= 1'b0;
            tx_serial_in <= ~tx_serial_in;
            rx_encoded_in <= rq[31] ^ f[k];
            rq = step(rq, f[k]);
        end
        @(posedge clock);
        busy <= 1'b0;
    endtask

    task automatic forward(input int n);
        @(posedge clock);
        tx_data_enable <= 1'b1;
        rx_pass_gate_n <= 1'b1;
        repeat (n) @(posedge clock);
        tx_data_enable <= 1'b0;
        rx_pass_gate_n <= 1'b0;
    endtask
endmodule // dsc_link_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dsc_pkg::*;
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    dsc_bus_req_t bus_req;
    logic [31:0]  bus_rdata, tq, rq;
    logic         crc_preset, crc_gate_term, tx_data_enable, tx_serial_in;
    logic         rx_encoded_in, rx_pass_gate_n, tx_encoded_out, rx_passthrough_out;
    logic         check_fail_flag, irq, e_tx, e_pt, e_fail, soft_pre;
    int           failures = 0;
    int           samples_checked = 0;

    always #50 clock = ~clock;

    dsc_dual_crc_codec u_dsc_dual_crc_codec (
        .clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .crc_preset(crc_preset), .crc_gate_term(crc_gate_term),
        .tx_data_enable(tx_data_enable), .tx_serial_in(tx_serial_in),
        .tx_encoded_out(tx_encoded_out), .rx_encoded_in(rx_encoded_in),
        .rx_pass_gate_n(rx_pass_gate_n), .rx_passthrough_out(rx_passthrough_out),
        .check_fail_flag(check_fail_flag), .irq(irq)
    );
    dsc_link_model u_dsc_link_model (
        .clock(clock), .crc_preset(crc_preset), .crc_gate_term(crc_gate_term),
        .tx_data_enable(tx_data_enable), .tx_serial_in(tx_serial_in),
        .rx_encoded_in(rx_encoded_in), .rx_pass_gate_n(rx_pass_gate_n)
    );

    // --------
    // Reference of both halves, compared every cycle
    // --------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tq <= CRC_PRESET;
            rq <= CRC_PRESET;
            {e_tx, e_pt, e_fail, soft_pre} <= 4'h0;
        end else begin
            if (bus_req.wr && bus_req.addr == OFS_CTRL)
                soft_pre <= bus_req.wdata[CTRL_PRESET_BIT];
            tq <= (crc_preset | soft_pre) ? CRC_PRESET
                : u_dsc_link_model.step(tq, crc_gate_term & (tq[31] ^ tx_serial_in));
            rq <= (crc_preset | soft_pre) ? CRC_PRESET
                : u_dsc_link_model.step(rq, rq[31] ^ rx_encoded_in);
            e_tx <= (crc_gate_term | tx_data_enable) ? tx_serial_in : tq[31];
            e_fail <= rq !== GOOD_RESIDUE;
            if (!rx_pass_gate_n)
                e_pt <= rx_encoded_in;
        end
    end

    always @(negedge clock) begin
        if (!rst) begin
            check(tx_encoded_out, e_tx);
            check(rx_passthrough_out, e_pt);
            check(check_fail_flag, e_fail);
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req.wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req.rd <= 1'b0;
        @(negedge clock);
        check(bus_rdata, exp);
    endtask

    task automatic scen_good_frame();
        u_dsc_link_model.frame(32'h5a3c_96e1, 32, GOOD_RESIDUE);
        @(posedge clock);
        @(negedge clock);
        check(check_fail_flag, 1'b0);
        bus_rd(OFS_TX_REM, 32'h0);
    endtask

    task automatic scen_events();
        bus_wr(OFS_ENABLE, 32'h1 << EV_GOOD);
        bus_rd(OFS_ENABLE, 32'h1 << EV_GOOD);
        check(irq, 1'b1);
        bus_wr(OFS_CLEAR, 32'h1 << EV_GOOD);
        bus_rd(8'h20, 32'h0);
        check(irq, 1'b0);
    endtask

    task automatic scen_bad_frame();
        u_dsc_link_model.frame(32'h0, 0, GOOD_RESIDUE ^ 32'h0000_0100);
        @(posedge clock);
        @(negedge clock);
        check(check_fail_flag, 1'b1);
    endtask

    task automatic scen_soft_preset();
        bus_wr(OFS_CTRL, 32'h1);
        bus_rd(OFS_CTRL, 32'h1);
        bus_rd(OFS_RX_REM, CRC_PRESET);
        bus_rd(OFS_TX_REM, CRC_PRESET);
        bus_wr(OFS_CTRL, 32'h2);
        bus_rd(OFS_FRAMES, 32'h0);
        bus_rd(OFS_CTRL, 32'h0);
    endtask

    task automatic scen_forward();
        u_dsc_link_model.forward(6);
        @(negedge clock);
        check(rx_passthrough_out, e_pt);
    endtask

    task automatic close_out();
        if (failures == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        close_out();
    end

    initial begin
        bus_req = '0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        scen_good_frame();
        scen_events();
        scen_bad_frame();
        scen_soft_preset();
        scen_forward();
        close_out();
    end
endmodule // tb_top
`default_nettype wire
